//--- include/tio_pkg.sv
// constants for the timed i/o port block: register map, control fields, reset values.
// assumes a 32-bit classic wishbone slave with byte addresses on adr_i.
package tio_pkg;
	localparam int TIO_NCB = 6;
	localparam int TIO_NP = 2;
	localparam logic [7:0] TIO_LINK_OFF = 8'h00;
	localparam logic [2:0] TIO_PORT_PAGE0 = 3'h2;
	localparam logic [4:0] TIO_R_CTRL = 5'h00;
	localparam logic [4:0] TIO_R_DATA = 5'h04;
	localparam logic [4:0] TIO_R_CMP = 5'h08;
	localparam logic [4:0] TIO_R_TIME = 5'h0c;
	localparam logic [4:0] TIO_R_COUNT = 5'h10;
	localparam logic [4:0] TIO_R_STAMP = 5'h14;
	localparam logic [4:0] TIO_R_STAT = 5'h18;
	localparam int TIO_C_EN = 0;
	localparam int TIO_C_OUT = 1;
	localparam int TIO_C_OD = 2;
	localparam int TIO_C_COND = 3;
	localparam int TIO_C_TIMED = 5;
	localparam int TIO_C_STRB = 6;
	localparam int TIO_C_CB = 8;
	localparam int TIO_CB_SRC = 16;
	localparam logic [31:0] TIO_CTRL_RST = 32'h0;
	localparam logic [16:0] TIO_CBCFG_RST = 17'h0;
	localparam logic [15:0] TIO_CNT_RST = 16'h0;
	localparam logic [1:0] TIO_COND_EQ = 2'h1;
	localparam logic [1:0] TIO_COND_NE = 2'h2;
	typedef enum {TIO_IDLE, TIO_RUN} tio_state_e;
endpackage

//--- verilog/tio_port.sv
// timed i/o port pair (wide port and 1-bit port) with six clock blocks, wishbone registers.
// assumes pins are synchronous to clk_i; the pad ring resolves pin_o/pin_oe_o into the wire.
`timescale 1ns/1ps
// Overview of operation
// - ports come in 1, 4, 8, 16 or 32 pin widths onto physical pins
// - all pins of one port are either inputs or outputs
// - port drives pins or samples them, sampling optionally waits for a condition
// - each processor port access completes within one cycle
// - open drain: zero pulls low, one leaves pin undriven, set per port
// - data moves through a shift register plus transfer register
// - each port has a 16-bit counter timing pin transfers
// - counter readable anytime; transfer can wait for a future count
// - each transfer captures the counter as a timestamp
// - enabled serial link disables ports on its pins
// - enabled narrower port overrides wider port on shared pins only
// - a port always transfers at its full nominal width
// - six clock blocks; block 0 is the reference clock, others programmable
// - a clock block may take its clock from a 1-bit port
// - such a pin-sourced clock may optionally be divided
// - ports accept an incoming strobe; only the wide port produces the outgoing strobe
// - after reset every port uses clock block 0
// - pin events go straight to the tile scheduler, no interrupts
module tio_port import tio_pkg::*; #(
	parameter int WIDE_W = 8,
	parameter int TR_W = 32,
	parameter int NARROW_PIN = 0,
	parameter int LINK_LO = 4,
	parameter int LINK_HI = 7
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [WIDE_W-1:0] pin_i,
	output logic [WIDE_W-1:0] pin_o,
	output logic [WIDE_W-1:0] pin_oe_o,
	input wire logic strobe_input_i,
	output logic strobe_output_o,
	output logic [TIO_NP-1:0] event_o
);
	function automatic logic port_sel(input logic [7:0] a, input int p);
		port_sel = a[7:5] == 3'(TIO_PORT_PAGE0 + 3'(p));
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		for (int b = 0; b < 4; b++)
			merge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
	endfunction

	function automatic logic cb_tick(input logic [TIO_NCB-1:0] t, input logic [2:0] s);
		cb_tick = (32'(s) < TIO_NCB) ? t[s] : 1'b0;
	endfunction

	logic wr;
	logic rd_take;
	logic link_en;
	logic pin0_q;
	logic pin0_q2;
	logic [TIO_NCB-1:0] tick;
	logic [31:0] port_rd [TIO_NP];
	logic [31:0] cb_rd [TIO_NCB];
	logic [TIO_NP-1:0] p_en;
	logic [TIO_NP-1:0] p_out;
	logic [TIO_NP-1:0] p_od;
	logic [TIO_NP-1:0] p_strb;
	logic [TIO_NP-1:0] p_ev;
	logic [WIDE_W-1:0] p_val [TIO_NP];
	logic [31:0] next_rd;

	// writes land on the edge where ack is high, so a held request writes again every second cycle
	assign wr = cyc_i && stb_i && we_i && ack_o;
	assign rd_take = cyc_i && stb_i && !we_i && ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
		end
	end

	always_comb begin
		next_rd = 32'h0;
		if (adr_i[7:5] == 3'h0)
			next_rd = cb_rd[3'(adr_i[4:2] % 3'(TIO_NCB))];
		for (int p = 0; p < TIO_NP; p++)
			if (port_sel(adr_i, p))
				next_rd = port_rd[p];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0;
		end else if (cyc_i && stb_i && !ack_o) begin
			dat_o <= next_rd;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_en <= 1'b0;
		end else if (wr && adr_i == TIO_LINK_OFF && sel_i[0]) begin
			link_en <= dat_i[0];
		end
	end

	// clock source pin is the 1-bit port's pin; edge found on registered copies
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin0_q <= 1'b0;
			pin0_q2 <= 1'b0;
		end else begin
			pin0_q <= pin_i[NARROW_PIN];
			pin0_q2 <= pin0_q;
		end
	end

	assign tick[0] = 1'b1;
	assign cb_rd[0] = {31'h0, link_en};

	genvar c;
	generate
		for (c = 1; c < TIO_NCB; c++) begin : g_cb
			logic [16:0] cfg;
			logic [15:0] cnt;
			logic t;
			logic src_ev;
			assign src_ev = cfg[TIO_CB_SRC] ? (pin0_q && !pin0_q2) : 1'b1;
			assign tick[c] = t;
			assign cb_rd[c] = {15'h0, cfg};
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cfg <= TIO_CBCFG_RST;
				end else if (wr && adr_i == 8'(4 * c)) begin
					cfg <= 17'(merge({15'h0, cfg}, dat_i, sel_i));
				end
			end
			// divide by cfg+1; zero passes every source edge through
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cnt <= TIO_CNT_RST;
					t <= 1'b0;
				end else begin
					t <= 1'b0;
					if (src_ev) begin
						if (cnt >= cfg[15:0]) begin
							cnt <= TIO_CNT_RST;
							t <= 1'b1;
						end else begin
							cnt <= cnt + 16'h1;
						end
					end
				end
			end
		end
	endgenerate

	genvar g;
	generate
		for (g = 0; g < TIO_NP; g++) begin : g_port
			localparam int PW = (g == 0) ? WIDE_W : 1;
			localparam int PLO = (g == 0) ? 0 : NARROW_PIN;
			localparam logic [5:0] NST = 6'(TR_W / PW);
			logic [31:0] ctrl;
			logic [31:0] cmp;
			logic [15:0] cnt;
			logic [15:0] tme;
			logic [15:0] stamp;
			logic [TR_W-1:0] tr;
			logic [TR_W-1:0] sh;
			logic [TR_W-1:0] next_sh;
			logic [PW-1:0] drv;
			logic [PW-1:0] chunk;
			logic [5:0] left;
			logic full;
			logic armed;
			logic strb_f;
			logic ev;
			logic tk;
			logic out;
			logic time_ok;
			logic cond_ok;
			logic sok;
			logic start;
			logic take;
			logic hit;
			tio_state_e st;

			assign hit = port_sel(adr_i, g);
			assign out = ctrl[TIO_C_OUT];
			assign tk = ctrl[TIO_C_EN] && cb_tick(tick, ctrl[TIO_C_CB +: 3]);
			assign chunk = pin_i[PLO +: PW];
			assign time_ok = !armed || cnt == tme;
			assign sok = !ctrl[TIO_C_STRB] || strobe_input_i;
			always_comb begin
				unique case (ctrl[TIO_C_COND +: 2])
					TIO_COND_EQ: cond_ok = chunk == cmp[PW-1:0];
					TIO_COND_NE: cond_ok = chunk != cmp[PW-1:0];
					default: cond_ok = 1'b1;
				endcase
			end
			assign start = tk && st == TIO_IDLE && time_ok && (out ? full : (cond_ok && sok));
			assign take = tk && !out && sok && (st == TIO_RUN || start);
			assign next_sh = (sh >> PW) | (TR_W'(chunk) << (TR_W - PW));

			always_comb begin
				unique case (adr_i[4:0])
					TIO_R_CTRL: port_rd[g] = ctrl;
					TIO_R_DATA: port_rd[g] = 32'(tr);
					TIO_R_CMP: port_rd[g] = cmp;
					TIO_R_TIME: port_rd[g] = {16'h0, tme};
					TIO_R_COUNT: port_rd[g] = {16'h0, cnt};
					TIO_R_STAMP: port_rd[g] = {16'h0, stamp};
					TIO_R_STAT: port_rd[g] = {29'h0, armed, st == TIO_RUN, full};
					default: port_rd[g] = 32'h0;
				endcase
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					ctrl <= TIO_CTRL_RST;
					cmp <= 32'h0;
					tme <= TIO_CNT_RST;
				end else if (wr && hit) begin
					if (adr_i[4:0] == TIO_R_CTRL)
						ctrl <= merge(ctrl, dat_i, sel_i);
					if (adr_i[4:0] == TIO_R_CMP)
						cmp <= merge(cmp, dat_i, sel_i);
					if (adr_i[4:0] == TIO_R_TIME)
						tme <= 16'(merge({16'h0, tme}, dat_i, sel_i));
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cnt <= TIO_CNT_RST;
				end else if (tk) begin
					cnt <= cnt + 16'h1;
				end
			end

			// a timed transfer arms on a time write and fires once at the match
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					armed <= 1'b0;
				end else if (wr && hit && adr_i[4:0] == TIO_R_TIME) begin
					armed <= ctrl[TIO_C_TIMED];
				end else if (start) begin
					armed <= 1'b0;
				end
			end

			// transfer register and shifter; a completed capture beats a read clear
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					st <= TIO_IDLE;
					tr <= '0;
					sh <= '0;
					drv <= '0;
					left <= 6'h0;
					full <= 1'b0;
					stamp <= TIO_CNT_RST;
					ev <= 1'b0;
					strb_f <= 1'b0;
				end else begin
					ev <= 1'b0;
					if (out) begin
						if (wr && hit && adr_i[4:0] == TIO_R_DATA) begin
							tr <= TR_W'(merge(32'(tr), dat_i, sel_i));
							full <= 1'b1;
						end else if (start) begin
							full <= 1'b0;
						end
						if (start) begin
							sh <= tr;
							left <= NST;
							st <= TIO_RUN;
							stamp <= cnt;
						end else if (tk && st == TIO_RUN) begin
							drv <= sh[PW-1:0];
							sh <= sh >> PW;
							strb_f <= 1'b1;
							left <= left - 6'h1;
							if (left == 6'h1) begin
								st <= TIO_IDLE;
								ev <= 1'b1;
							end
						end else if (tk) begin
							strb_f <= 1'b0;
						end
					end else begin
						strb_f <= 1'b0;
						if (take) begin
							sh <= next_sh;
							if ((st == TIO_RUN ? left : NST) == 6'h1) begin
								tr <= next_sh;
								full <= 1'b1;
								stamp <= cnt;
								st <= TIO_IDLE;
								ev <= 1'b1;
							end else begin
								left <= (st == TIO_RUN ? left : NST) - 6'h1;
								st <= TIO_RUN;
							end
						end else if (rd_take && hit && adr_i[4:0] == TIO_R_DATA) begin
							full <= 1'b0;
						end
					end
				end
			end

			assign p_en[g] = ctrl[TIO_C_EN];
			assign p_out[g] = out;
			assign p_od[g] = ctrl[TIO_C_OD];
			assign p_strb[g] = strb_f && ctrl[TIO_C_STRB];
			assign p_ev[g] = ev;
			assign p_val[g] = WIDE_W'(drv) << PLO;

			a_cnt_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
				tk && cnt == 16'hffff |=> cnt == 16'h0)
				else $error("port counter did not wrap to zero");
			a_reset_cb0: assert property (@(posedge clk_i)
				rst_i |=> ctrl[TIO_C_CB +: 3] == 3'h0 && !ctrl[TIO_C_EN])
				else $error("port not on clock block 0 after reset");
			a_stamp_cap: assert property (@(posedge clk_i) disable iff (rst_i)
				!out && $past(!out) && $rose(ev) |-> stamp == $past(cnt))
				else $error("timestamp not taken on capture");
			a_time_wait: assert property (@(posedge clk_i) disable iff (rst_i)
				st == TIO_IDLE && armed && cnt != tme |=> st == TIO_IDLE)
				else $error("transfer started before its time");
		end
	endgenerate

	// pin ownership: link first, then the narrow port, then the wide port
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_o <= '0;
			pin_oe_o <= '0;
		end else begin
			for (int i = 0; i < WIDE_W; i++) begin
				pin_o[i] <= 1'b0;
				pin_oe_o[i] <= 1'b0;
				if (i >= LINK_LO && i <= LINK_HI && link_en) begin
					pin_oe_o[i] <= 1'b0;
				end else if (i == NARROW_PIN && p_en[1]) begin
					pin_o[i] <= p_val[1][i] && !p_od[1];
					pin_oe_o[i] <= p_out[1] && (!p_od[1] || !p_val[1][i]);
				end else if (p_en[0]) begin
					pin_o[i] <= p_val[0][i] && !p_od[0];
					pin_oe_o[i] <= p_out[0] && (!p_od[0] || !p_val[0][i]);
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strobe_output_o <= 1'b0;
			event_o <= '0;
		end else begin
			strobe_output_o <= p_strb[0];
			event_o <= p_ev;
		end
	end

	a_bus_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
		cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus access not answered in one cycle");
	a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held for more than one cycle");
	a_link_off: assert property (@(posedge clk_i) disable iff (rst_i)
		link_en |=> pin_oe_o[LINK_HI:LINK_LO] == '0)
		else $error("pin driven under enabled link");
	a_narrow_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		p_en[1] && !p_out[1] |=> !pin_oe_o[NARROW_PIN])
		else $error("wide port drives pin owned by narrow input port");
	a_od_high: assert property (@(posedge clk_i) disable iff (rst_i)
		p_en[0] && p_od[0] && !link_en && !p_en[1] |=> pin_o[WIDE_W-1] == 1'b0)
		else $error("open drain pin driven high");
endmodule

//--- test/tio_pin_model.sv
// far-side hardware on the port pins: resolves the wire, plays one strobed word.
// assumes pads with pull-downs; play_i is a one-cycle request from the bench.
`timescale 1ns/1ps
module tio_pin_model (
	input wire logic clk_i,
	input wire logic play_i,
	input wire logic [7:0] pin_o_i,
	input wire logic [7:0] pin_oe_i,
	output logic [7:0] pin_wire_o,
	output logic strobe_o
);
	logic [2:0] step = 3'h0;
	logic [7:0] ext;
	always_ff @(posedge clk_i) begin
		if (play_i && step == 3'h0)
			step <= 3'h1;
		else if (step != 3'h0)
			step <= (step == 3'h4) ? 3'h0 : step + 3'h1;
	end
	// chunks a5, b6, c7, d8 on four consecutive cycles
	assign ext = 8'ha5 + 8'h11 * {5'h0, step - 3'h1};
	assign strobe_o = (step != 3'h0);
	// released pins fall to the pull-down level, not the last value
	assign pin_wire_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ((step != 3'h0) ? ext : 8'h00));
endmodule

//--- test/test_timed_io_port_with_clock_blocks.sv
// self-checking bench for tio_port: registers, output words, input words, counters.
// assumes the pin model above as the only far-side party.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module test_timed_io_port_with_clock_blocks import tio_pkg::*;;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, play = 1'b0;
	logic [3:0] sel = 4'hf;
	logic [7:0] adr = 8'h00, pin_wire, pin_o, pin_oe_o, b, eo, ev, om [6];
	logic [31:0] dat = 32'h0, dat_o, rd, oc [6], ic [3], icmp [3];
	logic [15:0] tgt, c1, d, dt;
	logic [1:0] event_o;
	logic ack_o, strobe_output_o, strobe_in, ss;
	int bad_count = 0, samples_checked = 0, cyc_n = 0, t_rd, ts, n, t1;
	tio_port dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.dat_i(dat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o), .pin_i(pin_wire), .pin_o(pin_o),
		.pin_oe_o(pin_oe_o), .strobe_input_i(strobe_in), .strobe_output_o(strobe_output_o), .event_o(event_o));
	tio_pin_model pm (.clk_i(clk_i), .play_i(play), .pin_o_i(pin_o), .pin_oe_i(pin_oe_o),
		.pin_wire_o(pin_wire), .strobe_o(strobe_in));
	always #5 clk_i = ~clk_i;
	task test_done;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// the whole run is well under a thousand cycles
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			bad_count++;
			test_done();
		end
	end
	function automatic logic [7:0] pa(input logic p, input logic [4:0] r);
		return {TIO_PORT_PAGE0 + {2'b0, p}, r};
	endfunction
	task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		ts = cyc_n;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		t_rd = cyc_n;
		cyc <= 1'b0;
		stb <= 1'b0;
		// raised after one edge, taken at the next, ack seen at the one after that
		`CHK(t_rd - ts, 2)
	endtask
	initial begin
		oc = '{32'h3, 32'h7, 32'h43, 32'h23, 32'h3, 32'h3};
		om = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h0e, 8'hfe};
		ic = '{32'h09, 32'h11, 32'h41};
		icmp = '{32'ha5, 32'h00, 32'h00};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		// output rows: plain, open drain, strobe, timed, link on, narrow port on pin 0
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, TIO_LINK_OFF, {31'h0, i == 4});
			// row 4 also enables the narrow port as an input, so pin 0 must stay undriven
			wb(1'b1, pa(1'b1, TIO_R_CTRL), (i == 5) ? 32'h3 : ((i == 4) ? 32'h1 : 32'h0));
			wb(1'b1, pa(1'b1, TIO_R_DATA), 32'h0);
			wb(1'b1, pa(1'b0, TIO_R_CTRL), oc[i]);
			wb(1'b0, pa(1'b0, TIO_R_COUNT), 32'h0);
			tgt = rd[15:0] + 16'd60;
			wb(1'b1, pa(1'b0, TIO_R_TIME), {16'h0, tgt});
			wb(1'b1, pa(1'b0, TIO_R_DATA), 32'h87654321);
			ss = 1'b0;
			for (int k = 0; k < 4; k++) begin
				b = 8'(32'h87654321 >> (8 * k));
				eo = oc[i][2] ? ~b : 8'hff;
				ev = oc[i][2] ? 8'h00 : b;
				n = 0;
				do begin
					@(posedge clk_i);
					n++;
					ss |= strobe_output_o;
				end while (k == 0 && n < 200 && ((pin_oe_o & om[i]) !== (eo & om[i]) || (pin_o & om[i]) !== (ev & om[i])));
				`CHK(pin_oe_o & om[i], eo & om[i])
				`CHK(pin_o & om[i], ev & om[i])
				if (i == 4)
					`CHK({pin_oe_o[7:4], pin_oe_o[0]}, 5'h0)
				if (i == 5)
					`CHK(pin_wire[0], 1'b0)
			end
			// the event pulse stands in the same cycle as the last chunk, so look before waiting
			n = 0;
			while (event_o[0] !== 1'b1 && n < 20) begin
				@(posedge clk_i);
				n++;
			end
			`CHK(event_o[0], 1'b1)
			if (i == 2)
				`CHK(ss, 1'b1)
			if (i == 3) begin
				wb(1'b0, pa(1'b0, TIO_R_STAMP), 32'h0);
				`CHK(rd[15:0], tgt)
			end
			$display("output row %0d done", i);
		end
		// input rows: wait equal, wait not equal, strobe gated
		wb(1'b1, pa(1'b1, TIO_R_CTRL), 32'h0);
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, pa(1'b0, TIO_R_CTRL), 32'h0);
			wb(1'b1, pa(1'b0, TIO_R_CMP), icmp[i]);
			wb(1'b1, pa(1'b0, TIO_R_CTRL), ic[i]);
			@(posedge clk_i);
			play <= 1'b1;
			@(posedge clk_i);
			play <= 1'b0;
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (event_o[0] !== 1'b1 && n < 30);
			`CHK(event_o[0], 1'b1)
			`CHK(pin_oe_o, 8'h00)
			wb(1'b0, pa(1'b0, TIO_R_STAT), 32'h0);
			`CHK(rd[0], 1'b1)
			wb(1'b0, pa(1'b0, TIO_R_DATA), 32'h0);
			`CHK(rd, 32'hd8c7b6a5)
			wb(1'b0, pa(1'b0, TIO_R_STAT), 32'h0);
			`CHK(rd[0], 1'b0)
			$display("input row %0d done", i);
		end
		// counter rate on block 0, block 1 dividing by 4, selector 6 (no such block) never ticking
		wb(1'b1, 8'h04, 32'h3);
		for (int j = 0; j < 3; j++) begin
			wb(1'b1, pa(1'b0, TIO_R_CTRL), {21'h0, 3'(j == 0 ? 0 : (j == 1 ? 1 : 6)), 8'h01});
			wb(1'b0, pa(1'b0, TIO_R_COUNT), 32'h0);
			c1 = rd[15:0];
			t1 = t_rd;
			repeat (40) @(posedge clk_i);
			wb(1'b0, pa(1'b0, TIO_R_COUNT), 32'h0);
			d = rd[15:0] - c1;
			dt = 16'(t_rd - t1);
			if (j == 0)
				`CHK(d, dt)
			if (j == 1)
				`CHK((d * 4 + 4 > dt) && (dt + 4 > d * 4), 1'b1)
			if (j == 2)
				`CHK(d, 16'h0)
		end
		// block 2 counts rising edges of pin 0; chunks a5, b6, c7, d8 give two
		wb(1'b1, 8'h08, 32'h10000);
		wb(1'b1, pa(1'b0, TIO_R_CTRL), 32'h201);
		wb(1'b0, pa(1'b0, TIO_R_COUNT), 32'h0);
		c1 = rd[15:0];
		play <= 1'b1;
		@(posedge clk_i);
		play <= 1'b0;
		repeat (10) @(posedge clk_i);
		wb(1'b0, pa(1'b0, TIO_R_COUNT), 32'h0);
		`CHK(rd[15:0] - c1, 16'h2)
		$display("counter test done");
		// reset values, then an unmapped place that must read zero
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, pa(1'b0, TIO_R_CTRL), 32'h0);
		`CHK(rd, TIO_CTRL_RST)
		wb(1'b0, pa(1'b1, TIO_R_CTRL), 32'h0);
		`CHK(rd, TIO_CTRL_RST)
		wb(1'b0, 8'h04, 32'h0);
		`CHK(rd[16:0], TIO_CBCFG_RST)
		wb(1'b0, pa(1'b0, TIO_R_COUNT), 32'h0);
		`CHK(rd[15:0], TIO_CNT_RST)
		wb(1'b1, 8'hfc, 32'hffffffff);
		wb(1'b0, 8'hfc, 32'h0);
		`CHK(rd, 32'h0)
		$display("reset test done");
		test_done();
	end
endmodule
